//--- rtl/fanout_defs.svh
// timing counts, widths and reset values of the clock fan-out driver
`ifndef FANOUT_DEFS_SVH
`define FANOUT_DEFS_SVH

`define FANOUT_CLK_MHZ        125
`define FANOUT_LOCK_TIME_MS   1
`define FANOUT_LOCK_CYCLES    (`FANOUT_LOCK_TIME_MS * `FANOUT_CLK_MHZ * 1000)
`define FANOUT_LOCK_CNT_W     17
`define FANOUT_PER_W          8
`define FANOUT_BANK_A_W       5
`define FANOUT_BANK_B_W       4
`define FANOUT_PER_RST        8'h00
`define FANOUT_LOCK_CNT_RST   17'h00000

`endif

//--- rtl/fanout_pkg.sv
// types shared by the clock fan-out driver
`include "fanout_defs.svh"

package fanout_pkg;

  // one registered snapshot of every output clock
  typedef struct packed {
    logic [`FANOUT_BANK_A_W-1:0] bank_a;
    logic [`FANOUT_BANK_B_W-1:0] bank_b;
    logic                        loop_return;
  } fanout_clocks_t;

  // loop acquisition state
  typedef enum logic {
    LOOP_ACQUIRE,
    LOOP_LOCKED
  } loop_state_t;

endpackage : fanout_pkg

//--- rtl/pll_clock_fanout_driver.sv
// behavioural clock fan-out driver: two gated banks, loop return, lock
//
// Operation
// - bank a enable low holds outputs low
// - bank b enable low holds outputs low
// - loop return output never gated; carries the regenerated clock, or the reference in bypass
// - outputs in phase; reference low forces low
// - outputs regenerated high for half the reference period, rounded down
// - loop aligns reference and loop return input
// - stabilization interval after power-up or change
// - grounded analog strap bypasses loop
// - lock within one millisecond at most
`timescale 1ns/10ps
`include "fanout_defs.svh"

module pll_clock_fanout_driver #(
  parameter int LOCK_CYCLES = `FANOUT_LOCK_CYCLES
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_ref_clock,
  input  wire logic                        i_bank_a_enable,
  input  wire logic                        i_bank_b_enable,
  input  wire logic                        i_loop_return_input,
  input  wire logic                        i_analog_supply_bypass_strap,
  output logic [`FANOUT_BANK_A_W-1:0]      o_bank_a_clock_outputs,
  output logic [`FANOUT_BANK_B_W-1:0]      o_bank_b_clock_outputs,
  output logic                             o_loop_return_output,
  output logic                             o_phase_locked
);

  localparam logic [`FANOUT_LOCK_CNT_W-1:0] LOCK_END =
    LOCK_CYCLES[`FANOUT_LOCK_CNT_W-1:0];

  logic                          ref_prev_ff;
  logic                          nxt_ref_prev;
  logic [`FANOUT_PER_W-1:0]      since_rise_ff;
  logic [`FANOUT_PER_W-1:0]      nxt_since_rise;
  logic [`FANOUT_PER_W-1:0]      period_ff;
  logic [`FANOUT_PER_W-1:0]      nxt_period;
  logic [`FANOUT_PER_W-1:0]      half_period;
  logic                          ref_rise;
  logic                          bypass;
  logic                          nxt_clk;

  logic                          en_a_ff;
  logic                          nxt_en_a;
  logic                          en_b_ff;
  logic                          nxt_en_b;
  fanout_pkg::fanout_clocks_t    clocks_ff;
  fanout_pkg::fanout_clocks_t    nxt_clocks;

  fanout_pkg::loop_state_t       state_ff;
  fanout_pkg::loop_state_t       nxt_state;
  logic [`FANOUT_LOCK_CNT_W-1:0] lock_cnt_ff;
  logic [`FANOUT_LOCK_CNT_W-1:0] nxt_lock_cnt;
  logic                          disturb;

  // strap low means the analog supply is grounded: loop bypassed
  assign bypass      = ~i_analog_supply_bypass_strap;
  assign ref_rise    = i_ref_clock & ~ref_prev_ff;
  assign half_period = period_ff >> 1;

  // reference edge tracking and period measurement
  always_comb
  begin
    nxt_ref_prev   = i_ref_clock;
    nxt_since_rise = since_rise_ff;
    nxt_period     = period_ff;
    if (ref_rise)
    begin
      nxt_period     = since_rise_ff;
      nxt_since_rise = 8'h01;
    end
    else if (since_rise_ff != 8'hFF)
    begin
      nxt_since_rise = since_rise_ff + 8'h01;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ref_prev_ff   <= 1'b0;
      since_rise_ff <= `FANOUT_PER_RST;
      period_ff     <= `FANOUT_PER_RST;
    end
    else
    begin
      ref_prev_ff   <= nxt_ref_prev;
      since_rise_ff <= nxt_since_rise;
      period_ff     <= nxt_period;
    end
  end

  // regenerated clock, bank gating and loop return
  always_comb
  begin
    if (bypass)
      nxt_clk = i_ref_clock;
    else
      nxt_clk = i_ref_clock &
                (ref_rise | (since_rise_ff < half_period));
    // enables are taken only while the clock sits low
    nxt_en_a = clocks_ff.loop_return ? en_a_ff : i_bank_a_enable;
    nxt_en_b = clocks_ff.loop_return ? en_b_ff : i_bank_b_enable;
    nxt_clocks.bank_a      = {`FANOUT_BANK_A_W{nxt_clk & nxt_en_a}};
    nxt_clocks.bank_b      = {`FANOUT_BANK_B_W{nxt_clk & nxt_en_b}};
    nxt_clocks.loop_return = nxt_clk;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      en_a_ff   <= 1'b0;
      en_b_ff   <= 1'b0;
      clocks_ff <= '0;
    end
    else
    begin
      en_a_ff   <= nxt_en_a;
      en_b_ff   <= nxt_en_b;
      clocks_ff <= nxt_clocks;
    end
  end

  // a period change or a loop return mismatch restarts acquisition
  assign disturb = (ref_rise & (since_rise_ff != period_ff)) |
                   (i_loop_return_input != clocks_ff.loop_return);

  // stabilization counter and lock state
  always_comb
  begin
    nxt_state    = state_ff;
    nxt_lock_cnt = lock_cnt_ff;
    if (bypass | disturb)
    begin
      nxt_state    = fanout_pkg::LOOP_ACQUIRE;
      nxt_lock_cnt = `FANOUT_LOCK_CNT_RST;
    end
    else
    begin
      unique case (state_ff)
        fanout_pkg::LOOP_ACQUIRE:
        begin
          if (lock_cnt_ff >= LOCK_END - 17'h00001)
            nxt_state = fanout_pkg::LOOP_LOCKED;
          nxt_lock_cnt = lock_cnt_ff + 17'h00001;
        end
        fanout_pkg::LOOP_LOCKED:
        begin
          nxt_lock_cnt = lock_cnt_ff;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_ff    <= fanout_pkg::LOOP_ACQUIRE;
      lock_cnt_ff <= `FANOUT_LOCK_CNT_RST;
    end
    else
    begin
      state_ff    <= nxt_state;
      lock_cnt_ff <= nxt_lock_cnt;
    end
  end

  // outputs straight from flip-flops
  assign o_bank_a_clock_outputs = clocks_ff.bank_a;
  assign o_bank_b_clock_outputs = clocks_ff.bank_b;
  assign o_loop_return_output   = clocks_ff.loop_return;
  assign o_phase_locked         = (state_ff == fanout_pkg::LOOP_LOCKED);

  // helper: length of the current high phase of the loop return
  logic [`FANOUT_PER_W-1:0] high_len_ff;
  logic [`FANOUT_PER_W-1:0] nxt_high_len;

  always_comb
  begin
    nxt_high_len = `FANOUT_PER_RST;
    if (clocks_ff.loop_return)
      nxt_high_len = (high_len_ff == 8'hFF) ? high_len_ff
                                            : high_len_ff + 8'h01;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      high_len_ff <= `FANOUT_PER_RST;
    else
      high_len_ff <= nxt_high_len;
  end

  default clocking chk_cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // a regenerated pulse has just ended while the loop is locked
  sequence pulse_ends_locked;
    $fell(o_loop_return_output) && o_phase_locked && !bypass;
  endsequence

  chk_bank_a_low: assert property (
    !en_a_ff |-> o_bank_a_clock_outputs == 5'h00)
    else $error("bank a drives while disabled");

  chk_bank_a_on: assert property (
    en_a_ff && o_loop_return_output |-> o_bank_a_clock_outputs == 5'h1F)
    else $error("bank a not following clock");

  chk_bank_b_low: assert property (
    !en_b_ff |-> o_bank_b_clock_outputs == 4'h0)
    else $error("bank b drives while disabled");

  chk_bank_b_on: assert property (
    en_b_ff && o_loop_return_output |-> o_bank_b_clock_outputs == 4'hF)
    else $error("bank b not following clock");

  chk_loop_return_rise: assert property (
    ref_rise && !bypass |=> o_loop_return_output)
    else $error("loop return missed reference rise");

  chk_ref_low_all: assert property (
    !i_ref_clock |=> !o_loop_return_output &&
      o_bank_a_clock_outputs == 5'h00 && o_bank_b_clock_outputs == 4'h0)
    else $error("output high while reference low");

  chk_half_duty: assert property (
    pulse_ends_locked |-> high_len_ff == half_period || !$past(i_ref_clock))
    else $error("high phase not half the period");

  chk_duty_bound: assert property (
    !bypass && o_phase_locked && half_period != 8'h00
      |-> high_len_ff <= half_period)
    else $error("regenerated duty above half");

  chk_return_mismatch: assert property (
    !bypass && (i_loop_return_input != o_loop_return_output)
      |=> !o_phase_locked ##1 lock_cnt_ff <= 17'h00001)
    else $error("mismatch did not restart lock");

  chk_lock_hold_off: assert property (
    $rose(o_phase_locked) |-> $past(lock_cnt_ff) == LOCK_END - 17'h00001)
    else $error("lock declared before interval");

  chk_lock_bound: assert property (
    lock_cnt_ff <= LOCK_END)
    else $error("stabilization counter past bound");

  chk_bypass_copy: assert property (
    bypass |=> o_loop_return_output == $past(i_ref_clock) && !o_phase_locked)
    else $error("bypass did not copy reference");

  chk_enable_low_only: assert property (
    $changed(en_a_ff) || $changed(en_b_ff) |-> !$past(o_loop_return_output))
    else $error("enable changed while clock high");

endmodule : pll_clock_fanout_driver

//--- dv/ref_clock_source.sv
// reference clock source model that feeds the fan-out driver
`timescale 1ns/10ps

module ref_clock_source (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_period,
  input  wire logic [7:0] i_high,
  output logic            o_ref,
  output logic            o_rise
);
  logic [7:0] cnt_ff  = 8'h00;
  logic       ref_ff  = 1'b0;
  logic       rise_ff = 1'b0;

  assign o_ref  = ref_ff;
  assign o_rise = rise_ff;

  // fixed period and phase while the settings hold
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_ff  <= 8'h00;
      ref_ff  <= 1'b0;
      rise_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= (cnt_ff + 8'h01 >= i_period) ? 8'h00 : cnt_ff + 8'h01;
      ref_ff  <= (cnt_ff < i_high);
      rise_ff <= (cnt_ff == 8'h00);
    end
  end
endmodule : ref_clock_source

//--- dv/testbench.sv
// self-checking bench of the clock fan-out driver
`timescale 1ns/10ps

module testbench;
  localparam logic [7:0] pt [5] = '{8'h04, 8'h04, 8'h05, 8'h05, 8'h05};
  localparam logic [7:0] ht [5] = '{8'h02, 8'h03, 8'h04, 8'h02, 8'h03};
  localparam logic       st [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        ena   = 1'b0;
  logic        enb   = 1'b0;
  logic        strap = 1'b1;
  logic        brk   = 1'b0;
  logic        arm   = 1'b0;
  logic [7:0]  per   = 8'h04;
  logic [7:0]  hi_in = 8'h02;
  logic [31:0] lfsr  = 32'hDDA3B2B6;
  logic [7:0]  hcnt  = 8'h00;
  logic        ref_clk, rise, lr, lock;
  logic [4:0]  bka, sa;
  logic [3:0]  bkb, sb;
  logic [16:0] q [$];
  int          n_fail = 0;
  int          checked = 0;
  int          t;

  always #4 i_clk = ~i_clk;

  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  ref_clock_source i_ref_clock_source (
    .i_clk(i_clk), .i_rst(i_rst), .i_period(per), .i_high(hi_in),
    .o_ref(ref_clk), .o_rise(rise));

  pll_clock_fanout_driver #(.LOCK_CYCLES(20)) i_pll_clock_fanout_driver (
    .i_clk(i_clk), .i_rst(i_rst), .i_ref_clock(ref_clk),
    .i_bank_a_enable(ena), .i_bank_b_enable(enb),
    .i_loop_return_input(lr ^ brk),
    .i_analog_supply_bypass_strap(strap),
    .o_bank_a_clock_outputs(bka), .o_bank_b_clock_outputs(bkb),
    .o_loop_return_output(lr), .o_phase_locked(lock));

  // note each expected pulse at a reference rise, then draw new enables
  always @(posedge i_clk)
    if (arm && rise)
    begin
      q.push_back({(strap ? per >> 1 : hi_in), {5{ena}}, {4{enb}}});
      lfsr = nxt(lfsr);
      ena <= lfsr[0];
      enb <= lfsr[1];
    end

  // measure each output pulse and compare it with the oldest note
  always @(negedge i_clk)
    if (lr === 1'b1)
    begin
      hcnt = hcnt + 8'h01;
      sa = bka;
      sb = bkb;
    end
    else if (lr === 1'b0)
    begin
      chk({8'h00, bka, bkb}, 17'h00000);
      if (hcnt != 8'h00 && q.size() > 0)
        chk({hcnt, sa, sb}, q.pop_front());
      hcnt = 8'h00;
    end

  // duty, enable and bypass phases, then a broken loop and relock
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      @(posedge i_clk);
      per <= pt[k];
      hi_in <= ht[k];
      strap <= st[k];
      repeat (40) @(posedge i_clk);
      arm <= 1'b1;
      repeat (40) @(posedge i_clk);
      arm <= 1'b0;
      repeat (12) @(posedge i_clk);
      @(negedge i_clk);
      chk({16'h0000, lock}, {16'h0000, st[k]});
    end
    @(posedge i_clk);
    strap <= 1'b1;
    repeat (40) @(posedge i_clk);
    brk <= 1'b1;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    chk({16'h0000, lock}, 17'h00000);
    @(posedge i_clk);
    brk <= 1'b0;
    t = 0;
    while (lock !== 1'b1 && t < 100)
    begin
      @(negedge i_clk);
      t++;
    end
    chk({16'h0000, t >= 20 && t <= 22}, 17'h00001);
    wrap_up();
  end
endmodule : testbench
